// ### design/control_word_command_decoder.sv
// Summary of operation
// R1: upper byte code, lower byte data
// R2: host writes 0x00 data for dataless codes
// R3: sixteen registers, inputs 1-6, outputs 9-14; code maps only register 15, other addresses read 0x0000
// R4: commands accepted only through register 15
// R5: code 0x01 forces full restart
// R6: gateway restart drops all nodes' sync
// R7: node restart affects only this node
// R8: restart loses output control temporarily
// R9: host avoids restart on running system
// R10: code 0x02 restores system defaults
// R11: code 0x03 restores I/O defaults; code does so only when role_io_proc_i is set
// R12: code 0x04 clears node message register
// R13: codes 0x04-0x08 only on gateway
// R14: code 0x05 ignores node error
// R15: code 0x06 writes 0xFE, disables messages
// R16: only 0x04 re-enables disabled messages
// R17: code 0x07 zeroes I/O link table
// R18: code 0x08 aborts active channel search
// R19: 0x1000 baselines strain-gauge nodes only
// R20: 0xFE upper byte suppresses node errors
// R21: word 0x0000 is no operation
// R22: undefined codes ignored without effects
`timescale 1ns/1ps
`default_nettype none
module control_word_command_decoder #(
   parameter int unsigned RESTART_CYCLES = ctrl_word_pkg::RESTART_CYC
) (
   // clock and reset
   input  wire logic                               ref_clk_i,
   input  wire logic                               rst_n_i,
   // register access
   input  wire logic                               reg_wr_i,
   input  wire logic                               reg_rd_i,
   input  wire logic [4:0]                         reg_addr_i,
   input  wire logic [15:0]                        reg_wdata_i,
   output var  logic [15:0]                        reg_rdata_o,
   // device role and status pins
   input  wire logic                               role_gateway_i,
   input  wire logic                               role_strain_i,
   input  wire logic                               role_io_proc_i,
   input  wire logic                               search_active_i,
   // node error reports and message readback
   input  wire logic                               err_valid_i,
   input  wire logic [ctrl_word_pkg::NODE_W-1:0]   err_node_i,
   input  wire logic [7:0]                         err_code_i,
   input  wire logic [ctrl_word_pkg::NODE_W-1:0]   msg_node_i,
   output var  logic [15:0]                        msg_rdata_o,
   output var  logic                               err_attention_o,
   // device actions
   output var  logic                               restart_o,
   output var  logic                               resync_all_o,
   output var  logic                               outputs_lost_o,
   output var  logic                               restore_sys_o,
   output var  logic                               restore_io_o,
   output var  logic                               link_clear_o,
   output var  logic                               search_abort_o,
   output var  logic                               baseline_o
);
   if (RESTART_CYCLES < 1 || RESTART_CYCLES > 65535) begin : g_bad_restart
      $error("RESTART_CYCLES out of range");
   end

   typedef enum logic [1:0] {
      ST_RUN     = 2'b01,
      ST_RESTART = 2'b10
   } state_type;

   msg_table_if tbl ();

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [3:0] pin_s1_r;
   logic [3:0] pin_s2_r;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_s1_r <= 4'h0;
         pin_s2_r <= 4'h0;
      end else begin
         pin_s1_r <= {search_active_i, role_io_proc_i, role_strain_i, role_gateway_i};
         pin_s2_r <= pin_s1_r;
      end
   end

   logic is_gw;
   logic is_strain;
   logic is_io_proc;
   logic srch_act;
   assign is_gw      = pin_s2_r[0];
   assign is_strain  = pin_s2_r[1];
   assign is_io_proc = pin_s2_r[2];
   assign srch_act   = pin_s2_r[3];

   function automatic logic node_ok(input logic [7:0] d);
      return (d >= ctrl_word_pkg::NODE_FIRST) && (d <= ctrl_word_pkg::NODE_LAST);
   endfunction

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   state_type   state_r;
   state_type   state_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [15:0] ctrl_r;
   logic [15:0] ctrl_nxt;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic        resync_r;
   logic        resync_nxt;
   logic [4:0]  act_r;
   logic [4:0]  act_nxt;
   logic        ctl_wr;
   logic [7:0]  code;
   logic [7:0]  dfield;

   // ctl_wr: only register 15 carries commands
   assign ctl_wr = reg_wr_i && (reg_addr_i == ctrl_word_pkg::REG_CONTROL); // [R4]
   assign code   = reg_wdata_i[ctrl_word_pkg::CODE_MSB:ctrl_word_pkg::CODE_LSB]; // [R1]
   assign dfield = reg_wdata_i[ctrl_word_pkg::DATA_MSB:ctrl_word_pkg::DATA_LSB]; // [R1]

   always_comb begin
      logic run_wr;
      logic no_dat;
      run_wr        = ctl_wr && (state_r == ST_RUN);
      no_dat        = (dfield == ctrl_word_pkg::DATA_NONE);
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      ctrl_nxt      = ctrl_r;
      resync_nxt    = resync_r;
      act_nxt       = 5'h00;
      tbl.cmd_valid = 1'b0;
      tbl.cmd_op    = ctrl_word_pkg::OP_NONE;
      tbl.cmd_node  = dfield[ctrl_word_pkg::NODE_W-1:0];
      if (run_wr) begin
         ctrl_nxt = reg_wdata_i;
      end
      unique case (state_r)
         ST_RUN: begin
            if (run_wr && no_dat) begin
               unique case (code)
                  ctrl_word_pkg::CODE_RESTART: begin                  // [R5]
                     state_nxt  = ST_RESTART;
                     cnt_nxt    = 16'(RESTART_CYCLES - 1);
                     resync_nxt = is_gw;                               // [R6] [R7]
                  end
                  ctrl_word_pkg::CODE_SYS_DEF:  act_nxt[0] = 1'b1;     // [R10]
                  ctrl_word_pkg::CODE_IO_DEF:   act_nxt[1] = is_io_proc; // [R11]
                  ctrl_word_pkg::CODE_LINK_CLR: act_nxt[2] = is_gw;    // [R17] [R13]
                  ctrl_word_pkg::CODE_SRCH_ABT: act_nxt[3] = is_gw && srch_act; // [R18] [R13]
                  ctrl_word_pkg::CODE_BASELINE: act_nxt[4] = is_strain; // [R19]
                  default: ;                                           // [R21] [R22]
               endcase
            end
            if (run_wr && is_gw && node_ok(dfield)) begin              // [R13]
               unique case (code)
                  ctrl_word_pkg::CODE_ERR_CLR: tbl.cmd_op = ctrl_word_pkg::OP_CLR; // [R12]
                  ctrl_word_pkg::CODE_ERR_IGN: tbl.cmd_op = ctrl_word_pkg::OP_IGN; // [R14]
                  ctrl_word_pkg::CODE_ERR_DIS: tbl.cmd_op = ctrl_word_pkg::OP_DIS; // [R15]
                  default: ;                                           // [R22]
               endcase
               tbl.cmd_valid = (tbl.cmd_op != ctrl_word_pkg::OP_NONE);
            end
         end
         ST_RESTART: begin                                             // [R8]
            if (cnt_r == 16'h0000) begin
               state_nxt  = ST_RUN;
               resync_nxt = 1'b0;
               ctrl_nxt   = ctrl_word_pkg::CTRL_RESET;
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
      rdata_nxt = rdata_r;
      if (reg_rd_i) begin
         rdata_nxt = (reg_addr_i == ctrl_word_pkg::REG_CONTROL) ? ctrl_r : 16'h0000; // [R3]
      end
   end

   assign tbl.rep_valid = err_valid_i;
   assign tbl.rep_node  = err_node_i;
   assign tbl.rep_code  = err_code_i;
   assign tbl.rd_node   = msg_node_i;

   node_msg_table u_table (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .tbl       (tbl.store)
   );

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r         <= ST_RUN;
         cnt_r           <= 16'h0000;
         ctrl_r          <= ctrl_word_pkg::CTRL_RESET;
         rdata_r         <= 16'h0000;
         resync_r        <= 1'b0;
         act_r           <= 5'h00;
         msg_rdata_o     <= 16'h0000;
         err_attention_o <= 1'b0;
      end else begin
         state_r         <= state_nxt;
         cnt_r           <= cnt_nxt;
         ctrl_r          <= ctrl_nxt;
         rdata_r         <= rdata_nxt;
         resync_r        <= resync_nxt;
         act_r           <= act_nxt;
         msg_rdata_o     <= tbl.rd_data;
         err_attention_o <= tbl.attention;
      end
   end

   assign reg_rdata_o    = rdata_r;
   assign restart_o      = state_r[1];
   assign outputs_lost_o = state_r[1];
   assign resync_all_o   = resync_r;
   assign restore_sys_o  = act_r[0];
   assign restore_io_o   = act_r[1];
   assign link_clear_o   = act_r[2];
   assign search_abort_o = act_r[3];
   assign baseline_o     = act_r[4];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_RESTART_START: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R5]
      (state_r == ST_RUN && ctl_wr && reg_wdata_i == 16'h0100) |=> restart_o)
      else $error("restart not started");

   // length of the current restart, for the length check
   logic [15:0] rst_len_r;
   logic [15:0] rst_len_nxt;

   always_comb begin
      rst_len_nxt = restart_o ? (rst_len_r + 16'h0001) : 16'h0000;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_len_r <= 16'h0000;
      end else begin
         rst_len_r <= rst_len_nxt;
      end
   end

   AST_RESTART_LEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R8]
      (restart_o |-> outputs_lost_o)
      and ($fell(restart_o) |-> (rst_len_r == 16'(RESTART_CYCLES))))
      else $error("restart length wrong");

   AST_RESYNC_GW: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R6]
      resync_all_o |-> (restart_o && is_gw))
      else $error("resync without gateway restart");

   AST_GW_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R13]
      !is_gw |-> ##1 (!link_clear_o && !search_abort_o))
      else $error("gateway code acted on node");

   AST_ABORT_NEEDS_SEARCH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R18]
      search_abort_o |-> $past(srch_act))
      else $error("abort without search");

   AST_BASELINE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R19]
      baseline_o |-> $past(is_strain) && $past(ctl_wr) && $past(reg_wdata_i) == 16'h1000)
      else $error("baseline wrongly issued");

   AST_NOP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R21]
      (state_r == ST_RUN && ctl_wr && reg_wdata_i == 16'h0000)
      |=> (act_r == 5'h00 && $stable(state_r)))
      else $error("noop had effect");

   AST_SYS_DEF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R10]
      (state_r == ST_RUN && ctl_wr && reg_wdata_i == 16'h0200) |=> restore_sys_o ##1 !restore_sys_o)
      else $error("system restore missing");

   AST_DISABLE_MSG: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R15]
      (state_r == ST_RUN && ctl_wr && is_gw && code == 8'h06 && dfield == {2'b00, msg_node_i}
       && node_ok(dfield) && !err_valid_i && $stable(msg_node_i))
      |=> ##1 (msg_rdata_o == 16'hFE00))
      else $error("disable did not mark node");

   AST_CLEAR_MSG: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)  // [R12]
      (state_r == ST_RUN && ctl_wr && is_gw && code == 8'h04 && dfield == {2'b00, msg_node_i}
       && node_ok(dfield) && !err_valid_i && $stable(msg_node_i))
      |=> ##1 (msg_rdata_o == 16'h0000))
      else $error("clear did not zero node");
endmodule // control_word_command_decoder
`default_nettype wire

// ### design/ctrl_word_pkg.sv
package ctrl_word_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int unsigned  NUM_REGS       = 16;
   localparam logic [4:0]   REG_CONTROL    = 5'h0F;
   localparam logic [15:0]  CTRL_RESET     = 16'h0000;
   localparam int unsigned  CODE_MSB       = 15;
   localparam int unsigned  CODE_LSB       = 8;
   localparam int unsigned  DATA_MSB       = 7;
   localparam int unsigned  DATA_LSB       = 0;

   // ------------------------------------------------------------
   // control codes
   // ------------------------------------------------------------
   localparam logic [7:0]   CODE_NOP       = 8'h00;
   localparam logic [7:0]   CODE_RESTART   = 8'h01;
   localparam logic [7:0]   CODE_SYS_DEF   = 8'h02;
   localparam logic [7:0]   CODE_IO_DEF    = 8'h03;
   localparam logic [7:0]   CODE_ERR_CLR   = 8'h04;
   localparam logic [7:0]   CODE_ERR_IGN   = 8'h05;
   localparam logic [7:0]   CODE_ERR_DIS   = 8'h06;
   localparam logic [7:0]   CODE_LINK_CLR  = 8'h07;
   localparam logic [7:0]   CODE_SRCH_ABT  = 8'h08;
   localparam logic [7:0]   CODE_BASELINE  = 8'h10;
   localparam logic [7:0]   DATA_NONE      = 8'h00;

   // ------------------------------------------------------------
   // node message table
   // ------------------------------------------------------------
   localparam int unsigned  MAX_NODE       = 56;
   localparam int unsigned  NODE_W         = 6;
   localparam logic [7:0]   NODE_FIRST     = 8'h01;
   localparam logic [7:0]   NODE_LAST      = 8'h38;
   localparam logic [7:0]   MSG_CLEARED    = 8'h00;
   localparam logic [7:0]   MSG_DISABLED   = 8'hFE;
   localparam logic [7:0]   MSG_REP_DATA   = 8'h01;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned  CLK_PERIOD_PS  = 8000;
   localparam int unsigned  RESTART_NS     = 1000;
   localparam int unsigned  RESTART_CYC    = (RESTART_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_CLR  = 2'h1,
      OP_IGN  = 2'h2,
      OP_DIS  = 2'h3
   } msg_op_type;
endpackage

// ### design/msg_table_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msg_table_if;
   logic                              cmd_valid;
   ctrl_word_pkg::msg_op_type         cmd_op;
   logic [ctrl_word_pkg::NODE_W-1:0]  cmd_node;
   logic                              rep_valid;
   logic [ctrl_word_pkg::NODE_W-1:0]  rep_node;
   logic [7:0]                        rep_code;
   logic [ctrl_word_pkg::NODE_W-1:0]  rd_node;
   logic [15:0]                       rd_data;
   logic                              attention;

   modport ctrl  (output cmd_valid, cmd_op, cmd_node, rep_valid, rep_node, rep_code, rd_node,
                  input rd_data, attention);
   modport store (input cmd_valid, cmd_op, cmd_node, rep_valid, rep_node, rep_code, rd_node,
                  output rd_data, attention);
endinterface
`default_nettype wire

// ### design/node_msg_table.sv
`timescale 1ns/1ps
`default_nettype none
module node_msg_table (
   // clock and reset
   input  wire logic  ref_clk_i,
   input  wire logic  rst_n_i,
   // table port
   msg_table_if.store tbl
);
   localparam int unsigned N = ctrl_word_pkg::MAX_NODE;

   logic [15:0] msg_r   [1:N];
   logic [15:0] msg_nxt [1:N];
   logic        ign_r   [1:N];
   logic        ign_nxt [1:N];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [ctrl_word_pkg::NODE_W-1:0] idx;
      logic                             attn;
      idx = '0;
      attn = 1'b0;
      for (int i = 1; i <= N; i++) begin
         idx        = ctrl_word_pkg::NODE_W'(i);
         msg_nxt[i] = msg_r[i];
         ign_nxt[i] = ign_r[i];
         if (tbl.cmd_valid && tbl.cmd_node == idx) begin
            unique case (tbl.cmd_op)
               ctrl_word_pkg::OP_CLR: begin
                  msg_nxt[i] = {ctrl_word_pkg::MSG_CLEARED, 8'h00};     // [R12] [R16]
                  ign_nxt[i] = 1'b0;
               end
               ctrl_word_pkg::OP_IGN: ign_nxt[i] = 1'b1;             // [R14]
               ctrl_word_pkg::OP_DIS: msg_nxt[i] = {ctrl_word_pkg::MSG_DISABLED, 8'h00}; // [R15]
               ctrl_word_pkg::OP_NONE: ;
            endcase
         end
         // report wins over a clear; a disabled node keeps its mark
         if (tbl.rep_valid && tbl.rep_node == idx
             && msg_nxt[i][15:8] != ctrl_word_pkg::MSG_DISABLED
             && (tbl.rep_code > msg_nxt[i][15:8] || msg_nxt[i][15:8] == 8'h00)) begin // [R20]
            msg_nxt[i] = {tbl.rep_code, ctrl_word_pkg::MSG_REP_DATA};
            ign_nxt[i] = 1'b0;
         end
         if (msg_r[i] != 16'h0000 && !ign_r[i]
             && msg_r[i][15:8] != ctrl_word_pkg::MSG_DISABLED) begin
            attn = 1'b1;
         end
      end
      tbl.attention = attn;
      tbl.rd_data   = 16'h0000;
      if (tbl.rd_node >= ctrl_word_pkg::NODE_W'(1) && tbl.rd_node <= ctrl_word_pkg::NODE_W'(N)) begin
         tbl.rd_data = msg_r[tbl.rd_node];
      end
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 1; i <= N; i++) begin
            msg_r[i] <= 16'h0000;
            ign_r[i] <= 1'b0;
         end
      end else begin
         for (int i = 1; i <= N; i++) begin
            msg_r[i] <= msg_nxt[i];
            ign_r[i] <= ign_nxt[i];
         end
      end
   end
endmodule // node_msg_table
`default_nettype wire

// ### tb/control_word_command_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module control_word_command_decoder_test;
   localparam int unsigned RST_CYC = 4;
   logic        ref_clk;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [15:0] msg_rdata;
   logic [15:0] v;
   logic        gw, strain, iop, srch, err_v;
   logic [5:0]  err_node;
   logic [5:0]  msg_node;
   logic [7:0]  err_code;
   logic        att, rs, rsa, ol, rsys, rio, lclr, sabt, base;
   logic [4:0]  acts;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          n;
   logic [7:0]  codes [5];
   assign acts = {rsys, rio, lclr, sabt, base};

   // ------------------------------------------------------------
   // instances and clock
   // ------------------------------------------------------------
   control_word_command_decoder #(.RESTART_CYCLES(RST_CYC)) i_control_word_command_decoder (
      .ref_clk_i(ref_clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .role_gateway_i(gw), .role_strain_i(strain), .role_io_proc_i(iop),
      .search_active_i(srch), .err_valid_i(err_v), .err_node_i(err_node),
      .err_code_i(err_code), .msg_node_i(msg_node), .msg_rdata_o(msg_rdata),
      .err_attention_o(att), .restart_o(rs), .resync_all_o(rsa), .outputs_lost_o(ol),
      .restore_sys_o(rsys), .restore_io_o(rio), .link_clear_o(lclr),
      .search_abort_o(sabt), .baseline_o(base));
   modbus_host_model i_modbus_host_model (
      .ref_clk_i(ref_clk), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata));
   initial begin
      ref_clk = 1'h0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] d, input logic [4:0] e);
      i_modbus_host_model.send_cmd(c, d);
      chk({11'h000, acts}, {11'h000, e}, "action pulse");
      @(negedge ref_clk);
      chk({11'h000, acts}, 16'h0000, "action pulse width");
   endtask
   // straps pass a two-flop synchroniser
   task automatic setr(input logic g, input logic s, input logic i, input logic a);
      @(negedge ref_clk);
      {gw, strain, iop, srch} = {g, s, i, a};
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic rep(input logic [5:0] node, input logic [7:0] code);
      @(negedge ref_clk);
      {err_v, err_node, err_code} = {1'h1, node, code};
      @(negedge ref_clk);
      err_v = 1'h0;
   endtask
   task automatic look(input logic [5:0] node);
      msg_node = node;
      repeat (3) @(negedge ref_clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk({7'h00, acts, rs, rsa, ol, att}, 16'h0000, "outputs after reset");
      i_modbus_host_model.read_word(ctrl_word_pkg::REG_CONTROL, v);
      chk(v, ctrl_word_pkg::CTRL_RESET, "control word reset");
   endtask
   task automatic t_regs();
      setr(1'h1, 1'h1, 1'h1, 1'h1);
      cmd(ctrl_word_pkg::CODE_NOP, ctrl_word_pkg::DATA_NONE, 5'h00);
      cmd(8'h20, 8'h00, 5'h00);
      i_modbus_host_model.read_word(5'h0F, v);
      chk(v, 16'h2000, "stored word");
      i_modbus_host_model.write_word(5'h07, 16'h0200);
      chk({11'h000, acts}, 16'h0000, "write to message register");
      i_modbus_host_model.read_word(5'h07, v);
      chk(v, 16'h0000, "read of register 7");
      i_modbus_host_model.read_word(5'h00, v);
      chk(v, 16'h0000, "unmapped read");
      i_modbus_host_model.read_word(5'h0F, v);
      chk(v, 16'h2000, "control word kept");
   endtask
   task automatic t_actions();
      codes = '{ctrl_word_pkg::CODE_SYS_DEF, ctrl_word_pkg::CODE_IO_DEF,
                ctrl_word_pkg::CODE_LINK_CLR, ctrl_word_pkg::CODE_SRCH_ABT,
                ctrl_word_pkg::CODE_BASELINE};
      for (int i = 0; i < 5; i++) begin
         cmd(codes[i], ctrl_word_pkg::DATA_NONE, 5'h10 >> i);
      end
      cmd(ctrl_word_pkg::CODE_SYS_DEF, 8'h01, 5'h00);
   endtask
   task automatic t_refuse();
      setr(1'h0, 1'h0, 1'h0, 1'h0);
      cmd(ctrl_word_pkg::CODE_SYS_DEF, ctrl_word_pkg::DATA_NONE, 5'h10);
      for (int i = 1; i < 5; i++) begin
         cmd(codes[i], ctrl_word_pkg::DATA_NONE, 5'h00);
      end
      setr(1'h1, 1'h1, 1'h1, 1'h0);
      cmd(ctrl_word_pkg::CODE_SRCH_ABT, ctrl_word_pkg::DATA_NONE, 5'h00);
   endtask
   // gateway and node restart; a command written during the restart is ignored
   task automatic t_restart();
      i_modbus_host_model.send_cmd(ctrl_word_pkg::CODE_RESTART, ctrl_word_pkg::DATA_NONE);
      chk({13'h0000, rs, ol, rsa}, 16'h0007, "gateway restart");
      i_modbus_host_model.send_cmd(ctrl_word_pkg::CODE_SYS_DEF, ctrl_word_pkg::DATA_NONE);
      chk({11'h000, acts}, 16'h0000, "write during restart");
      n = 3;
      while (rs === 1'h1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk(16'(n), 16'(RST_CYC + 1), "restart length");
      i_modbus_host_model.read_word(5'h0F, v);
      chk(v, 16'h0000, "word after restart");
      setr(1'h0, 1'h1, 1'h1, 1'h1);
      i_modbus_host_model.send_cmd(ctrl_word_pkg::CODE_RESTART, ctrl_word_pkg::DATA_NONE);
      chk({13'h0000, rs, ol, rsa}, 16'h0006, "node restart");
      repeat (RST_CYC + 1) @(negedge ref_clk);
      chk({15'h0000, rs}, 16'h0000, "node restart over");
   endtask
   task automatic t_msg();
      setr(1'h1, 1'h1, 1'h1, 1'h1);
      rep(6'h03, 8'h35);
      rep(6'h03, 8'h36);
      rep(6'h03, 8'h35);
      look(6'h03);
      chk(msg_rdata, 16'h3601, "highest code kept");
      chk({15'h0000, att}, 16'h0001, "attention set");
      cmd(ctrl_word_pkg::CODE_ERR_CLR, 8'h03, 5'h00);
      look(6'h03);
      chk(msg_rdata, 16'h0000, "cleared node");
      chk({15'h0000, att}, 16'h0000, "attention clear");
      look(6'h05);
      cmd(ctrl_word_pkg::CODE_ERR_DIS, 8'h05, 5'h00);
      rep(6'h05, 8'h36);
      look(6'h05);
      chk({8'h00, msg_rdata[15:8]}, {8'h00, ctrl_word_pkg::MSG_DISABLED}, "disabled");
      chk({15'h0000, att}, 16'h0000, "disabled node silent");
      cmd(ctrl_word_pkg::CODE_ERR_IGN, 8'h05, 5'h00);
      look(6'h05);
      chk({8'h00, msg_rdata[15:8]}, {8'h00, ctrl_word_pkg::MSG_DISABLED}, "still off");
      cmd(ctrl_word_pkg::CODE_ERR_CLR, 8'h05, 5'h00);
      rep(6'h05, 8'h35);
      look(6'h05);
      chk(msg_rdata, 16'h3501, "re-enabled");
      cmd(ctrl_word_pkg::CODE_ERR_IGN, 8'h05, 5'h00);
      look(6'h05);
      chk({15'h0000, att}, 16'h0000, "ignored error");
      chk(msg_rdata, 16'h3501, "ignored message kept");
      setr(1'h0, 1'h1, 1'h1, 1'h1);
      cmd(ctrl_word_pkg::CODE_ERR_CLR, 8'h05, 5'h00);
      look(6'h05);
      chk(msg_rdata, 16'h3501, "clear on non-gateway");
   endtask

   initial begin
      {rst_n, gw, strain, iop, srch, err_v} = 6'h00;
      {err_node, msg_node, err_code} = 20'h00000;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'h1;
      repeat (3) @(negedge ref_clk);
      t_reset();
      t_regs();
      t_actions();
      t_refuse();
      t_restart();
      t_msg();
      complete_run();
   end
endmodule // control_word_command_decoder_test
`default_nettype wire

// ### tb/modbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module modbus_host_model (
   // clock
   input  wire logic        ref_clk_i,
   // register bus
   output var  logic        reg_wr_o,
   output var  logic        reg_rd_o,
   output var  logic [4:0]  reg_addr_o,
   output var  logic [15:0] reg_wdata_o,
   input  wire logic [15:0] reg_rdata_i
);
   initial begin
      reg_wr_o    = 1'h0;
      reg_rd_o    = 1'h0;
      reg_addr_o  = 5'h00;
      reg_wdata_o = 16'h0000;
   end
   // one-cycle strobe; released lines show the inverse
   task automatic write_word(input logic [4:0] a, input logic [15:0] d);
      @(negedge ref_clk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'h1;
      @(negedge ref_clk_i);
      reg_wr_o    = 1'h0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask
   task automatic send_cmd(input logic [7:0] code, input logic [7:0] data);
      write_word(ctrl_word_pkg::REG_CONTROL, {code, data});
   endtask
   task automatic read_word(input logic [4:0] a, output logic [15:0] d);
      @(negedge ref_clk_i);
      reg_addr_o = a;
      reg_rd_o   = 1'h1;
      @(negedge ref_clk_i);
      reg_rd_o   = 1'h0;
      reg_addr_o = ~a;
      d          = reg_rdata_i;
   endtask
endmodule // modbus_host_model
`default_nettype wire
